// ### mipc_ctrl.sv
`timescale 1ns/1ps
// Function
// - request sets flag, accepted entry clears it
// - level zero disables, seven is highest
// - mask n enables levels above n
// - accept needs enable, flag, level above mask
// - judge after instruction end, enter next cycle
// - string instructions suspend for entry
// - entry first reads address zero, clears flag
// - save flags, clear enable, step, stack (stack kept for soft number above 31)
// - push flags, push pc, mask, vector
// - entry takes exactly twenty cycles
// - mask load per source class
// - flags word then pc, byte per step
// - return pops flags and pc
// - highest priority wins, fixed tie order
// - ext0 enable bit and edge selection
// - ext0 three agreeing filter samples
// - ext1 edge bit and pin select
// - ext3 source and sync select
// - ext3 filter aligns to sampling clock
// - port bit shows raw ext3 level
// - ring clock drives ext3 requests
module mipc_ctrl #(
  parameter int N_SRC = mipc_pkg::NUM_SRC
) (
  input  wire logic                          I_CLK,
  input  wire logic                          I_SYS_RST,
  input  wire logic [N_SRC-1:0]              I_SRC_REQ,
  input  wire logic [N_SRC*3-1:0]            I_SRC_LVL,
  input  wire logic [N_SRC-1:0]              I_FLAG_CLR,
  input  wire logic                          I_INSTR_END,
  input  wire logic                          I_STRING_OP,
  input  wire logic                          I_SPECIAL_REQ,
  input  wire logic                          I_SOFT_REQ,
  input  wire logic [5:0]                    I_SOFT_NUM,
  input  wire logic                          I_RETURN_INSTR,
  input  wire logic [7:0]                    I_POP_DATA,
  input  wire logic [7:0]                    I_FLAG_IN,
  input  wire logic [2:0]                    I_MASK_IN,
  input  wire logic                          I_MASK_WR,
  input  wire logic [19:0]                   I_PC,
  input  wire logic [19:0]                   I_VECTOR,
  input  wire mipc_pkg::mipc_ext_cfg_s       I_EXT_CFG,
  input  wire logic                          I_EXT0_INPUT,
  input  wire logic                          I_EXT1_FIRST_PIN,
  input  wire logic                          I_EXT1_SECOND_PIN,
  input  wire logic                          I_EXT3_INPUT,
  input  wire logic [2:0]                    I_SAMPLE_TICK,
  input  wire logic                          I_CAPTURE_TICK,
  input  wire logic                          I_RING_CLK,
  input  wire logic                          I_RING_HALF,
  output logic [N_SRC-1:0]                   O_REQ_FLAG,
  output logic [2:0]                         O_MASK,
  output logic [7:0]                         O_FLAGS,
  output logic [19:0]                        O_PC,
  output logic                               O_PC_LOAD,
  output mipc_pkg::mipc_bus_s                O_BUS,
  output logic                               O_ENTRY_BUSY,
  output logic                               O_SUSPEND,
  output logic [7:0]                         O_INFO,
  output logic                               O_PORT3_LINE3
);
  import mipc_pkg::*;

  initial begin
    if (N_SRC < 4 || N_SRC > 8) $error("N_SRC must be 4..8");
  end

  // sources 0..2 are the external pins, the rest are peripherals
  localparam int E0 = 0;
  localparam int E1 = 1;
  localparam int E3 = 2;

  mipc_state_e state_reg, state_next;
  logic [4:0]       cyc_reg;
  logic [N_SRC-1:0] flag_reg;
  logic [2:0]       mask_reg;
  logic [7:0]       flg_reg, flg_tmp_reg;
  logic [19:0]      pc_reg, ret_pc_reg;
  logic [2:0]       acc_idx_reg, acc_lvl_reg;
  logic [1:0]       acc_cls_reg;
  logic             pc_load_reg, busy_reg, susp_reg, port_reg;
  logic [7:0]       info_reg;
  mipc_bus_s        bus_reg;

  // ext0 filter and edge detect
  logic [1:0] e0_cnt_reg;
  logic       e0_lvl_reg, e0_prev_reg;
  logic       e0_tick, e0_agree, e0_edge;
  assign e0_tick  = (I_EXT_CFG.e0_clk_sel == 2'h0) ? 1'b1 : I_SAMPLE_TICK[I_EXT_CFG.e0_clk_sel-1];
  assign e0_agree = e0_tick && (I_EXT0_INPUT != e0_lvl_reg) && (e0_cnt_reg == 2'(FILT_MATCH-1));
  // both-edge mode fires on any change; else polarity picks rise or fall
  assign e0_edge  = I_EXT_CFG.e0_en && (e0_lvl_reg != e0_prev_reg) &&
                    (I_EXT_CFG.e0_both || (e0_lvl_reg == I_EXT_CFG.e0_pol));

  // ext1 pin route and edge
  logic e1_pin, e1_prev_reg, e1_edge;
  assign e1_pin  = I_EXT_CFG.e1_pin_sel ? I_EXT1_SECOND_PIN : I_EXT1_FIRST_PIN;
  assign e1_edge = (e1_pin != e1_prev_reg) && (e1_pin == I_EXT_CFG.e1_edge);

  // ext3 filter, sync and ring source
  logic [1:0] e3_cnt_reg;
  logic       e3_lvl_reg, e3_prev_reg, e3_pend_reg;
  logic       e3_filt, e3_tick, e3_chg, e3_pin_edge, e3_ring_edge, e3_edge;
  assign e3_filt  = (I_EXT_CFG.e3_clk_sel != 2'h0);
  assign e3_tick  = e3_filt ? I_SAMPLE_TICK[I_EXT_CFG.e3_clk_sel-1] : 1'b1;
  assign e3_chg   = e3_tick && (I_EXT3_INPUT != e3_lvl_reg) &&
                    (!e3_filt || e3_cnt_reg == 2'(FILT_MATCH-1));
  assign e3_pin_edge = (e3_lvl_reg != e3_prev_reg) && !e3_lvl_reg;
  // filtered input is already tick aligned, so it ignores the capture tick
  assign e3_ring_edge = I_RING_HALF ? (I_RING_CLK != e3_prev_reg) : (I_RING_CLK && !e3_prev_reg);
  assign e3_edge  = I_EXT_CFG.e3_src_sel ? e3_ring_edge :
                    (I_EXT_CFG.e3_sync_sel || e3_filt) ? e3_pin_edge :
                    (e3_pend_reg && I_CAPTURE_TICK);

  // raise vector from pins and peripherals
  logic [N_SRC-1:0] raise;
  assign raise = {I_SRC_REQ[N_SRC-1:3], e3_edge, e1_edge, e0_edge};

  // priority judgement: strict level above mask, ties go to lower index
  logic [N_SRC-1:0] elig;
  logic [2:0]       best_lvl, best_idx;
  logic             best_vld;
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_elig
      assign elig[g] = flg_reg[FLG_IEN_POS] && flag_reg[g] &&
                       (I_SRC_LVL[g*3 +: 3] != LVL_OFF) &&
                       (I_SRC_LVL[g*3 +: 3] > mask_reg);
    end
  endgenerate
  always_comb begin
    best_vld = 1'b0;
    best_lvl = LVL_OFF;
    best_idx = 3'h0;
    for (int i = N_SRC-1; i >= 0; i--) begin
      if (elig[i] && I_SRC_LVL[i*3 +: 3] >= best_lvl) begin
        best_vld = 1'b1;
        best_lvl = I_SRC_LVL[i*3 +: 3];
        best_idx = 3'(i);
      end
    end
  end

  // start conditions: special beats soft beats maskable
  logic any_req, start;
  assign any_req = I_SPECIAL_REQ || I_SOFT_REQ || best_vld;
  assign start   = (state_reg == MIPC_IDLE) && any_req && (I_INSTR_END || I_STRING_OP);

  // sequence state transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MIPC_IDLE: begin
        if (start) state_next = MIPC_INFO;
        else if (I_RETURN_INSTR) state_next = MIPC_RET;
      end
      MIPC_INFO: state_next = MIPC_PUSH;
      MIPC_PUSH: if (cyc_reg == 5'd5) state_next = MIPC_LOAD;
      MIPC_LOAD: if (cyc_reg == 5'(ENTRY_CYCLES-1)) state_next = MIPC_IDLE;
      MIPC_RET:  if (cyc_reg == 5'd4) state_next = MIPC_IDLE;
      default:   state_next = MIPC_IDLE;
    endcase
  end

  // pop address runs one cycle ahead of the byte it fetches, since the
  // stack answers the address that the bus already shows
  logic [19:0] pop_addr;
  assign pop_addr = (state_reg == MIPC_IDLE) ? 20'h00003 :
                    (cyc_reg == 5'd0) ? 20'h00002 : 20'(cyc_reg + 5'd3);

  // push bytes: flags word then low pc, one byte per step
  logic [7:0] push_byte;
  always_comb begin
    case (cyc_reg)
      5'd2:    push_byte = {ret_pc_reg[19:16], 1'b0, mask_reg};
      5'd3:    push_byte = flg_tmp_reg;
      5'd4:    push_byte = ret_pc_reg[15:8];
      default: push_byte = ret_pc_reg[7:0];
    endcase
  end

  // filter and edge history
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      e0_cnt_reg <= 2'h0; e0_lvl_reg <= 1'b1; e0_prev_reg <= 1'b1;
      e1_prev_reg <= 1'b1; e3_cnt_reg <= 2'h0; e3_lvl_reg <= 1'b1;
      e3_prev_reg <= 1'b1; e3_pend_reg <= 1'b0; port_reg <= 1'b1;
    end else begin
      if (e0_tick) e0_cnt_reg <= (I_EXT0_INPUT != e0_lvl_reg && !e0_agree) ? e0_cnt_reg + 2'h1 : 2'h0;
      if (e0_agree) e0_lvl_reg <= I_EXT0_INPUT;
      e0_prev_reg <= e0_lvl_reg;
      e1_prev_reg <= e1_pin;
      if (e3_tick) e3_cnt_reg <= (I_EXT3_INPUT != e3_lvl_reg && !e3_chg) ? e3_cnt_reg + 2'h1 : 2'h0;
      if (e3_chg) e3_lvl_reg <= I_EXT3_INPUT;
      e3_prev_reg <= I_EXT_CFG.e3_src_sel ? I_RING_CLK : e3_lvl_reg;
      e3_pend_reg <= (e3_pend_reg && !I_CAPTURE_TICK) || e3_pin_edge;
      port_reg <= I_EXT3_INPUT;
    end
  end

  // request flags: raise wins over software or entry clear
  logic [N_SRC-1:0] ent_clr;
  assign ent_clr = (state_reg == MIPC_INFO && acc_cls_reg == CLS_MASKABLE) ?
                   (N_SRC'(1) << acc_idx_reg) : '0;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) flag_reg <= '0;
    else flag_reg <= (flag_reg & ~(I_FLAG_CLR | ent_clr)) | raise;
  end

  // sequencer datapath
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_reg <= MIPC_IDLE; cyc_reg <= 5'h0; mask_reg <= 3'h0;
      flg_reg <= 8'h00; flg_tmp_reg <= 8'h00; pc_reg <= 20'h00000;
      ret_pc_reg <= 20'h00000; acc_idx_reg <= 3'h0; acc_lvl_reg <= 3'h0;
      acc_cls_reg <= CLS_MASKABLE; pc_load_reg <= 1'b0; busy_reg <= 1'b0;
      susp_reg <= 1'b0; info_reg <= 8'h00; bus_reg <= '0;
    end else begin
      state_reg   <= state_next;
      cyc_reg     <= (state_next == MIPC_IDLE || state_reg == MIPC_IDLE) ? 5'h0 : cyc_reg + 5'h1;
      pc_load_reg <= 1'b0;
      bus_reg     <= '0;
      busy_reg    <= (state_next != MIPC_IDLE);
      if (state_reg == MIPC_IDLE) begin
        if (I_MASK_WR) mask_reg <= I_MASK_IN;
        flg_reg <= I_FLAG_IN;
        pc_reg  <= I_PC;
      end
      if (start) begin
        susp_reg    <= !I_INSTR_END;
        ret_pc_reg  <= I_PC;
        flg_tmp_reg <= I_FLAG_IN;
        acc_cls_reg <= I_SPECIAL_REQ ? CLS_SPECIAL : I_SOFT_REQ ? CLS_SOFT : CLS_MASKABLE;
        acc_idx_reg <= best_idx;
        acc_lvl_reg <= best_lvl;
        flg_reg[FLG_IEN_POS]   <= 1'b0;
        flg_reg[FLG_DSTEP_POS] <= 1'b0;
        if (!(I_SOFT_REQ && !I_SPECIAL_REQ && I_SOFT_NUM[5]))
          flg_reg[FLG_USTACK_POS] <= 1'b0;
        bus_reg.rd   <= 1'b1;
        bus_reg.addr <= INFO_ADDR;
      end
      if (state_reg == MIPC_INFO) begin
        info_reg <= {2'h0, acc_idx_reg, acc_lvl_reg};
        susp_reg <= 1'b0;
      end
      if (state_reg == MIPC_PUSH && cyc_reg >= 5'd2) begin
        bus_reg.wr    <= 1'b1;
        bus_reg.addr  <= 20'(cyc_reg);
        bus_reg.wdata <= push_byte;
      end
      if (state_reg == MIPC_LOAD && cyc_reg == 5'd6) begin
        if (acc_cls_reg == CLS_MASKABLE) mask_reg <= acc_lvl_reg;
        else if (acc_cls_reg == CLS_SPECIAL) mask_reg <= LVL_MAX;
      end
      if (state_reg == MIPC_LOAD && cyc_reg == 5'(ENTRY_CYCLES-1)) begin
        pc_reg      <= I_VECTOR;
        pc_load_reg <= 1'b1;
      end
      if (state_reg == MIPC_IDLE && !start && I_RETURN_INSTR) begin
        bus_reg.rd   <= 1'b1;
        bus_reg.addr <= pop_addr;
      end
      if (state_reg == MIPC_RET) begin
        bus_reg.rd   <= (cyc_reg < 5'd3);
        bus_reg.addr <= pop_addr;
        case (cyc_reg)
          5'd0: flg_reg <= I_POP_DATA;
          5'd1: begin
            mask_reg <= I_POP_DATA[2:0];
            pc_reg[19:16] <= I_POP_DATA[7:4];
          end
          5'd2: pc_reg[15:8] <= I_POP_DATA;
          5'd3: pc_reg[7:0] <= I_POP_DATA;
          default: pc_load_reg <= 1'b1;
        endcase
      end
    end
  end

  assign O_REQ_FLAG    = flag_reg;
  assign O_MASK        = mask_reg;
  assign O_FLAGS       = flg_reg;
  assign O_PC          = pc_reg;
  assign O_PC_LOAD     = pc_load_reg;
  assign O_BUS         = bus_reg;
  assign O_ENTRY_BUSY  = busy_reg;
  assign O_SUSPEND     = susp_reg;
  assign O_INFO        = info_reg;
  assign O_PORT3_LINE3 = port_reg;

  // checks
  a_entry_len: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    start |-> ##21 pc_load_reg) else $error("entry not 20 cycles");
  a_info_read: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    start |=> bus_reg.rd && bus_reg.addr == INFO_ADDR) else $error("no info read");
  a_flag_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    raise[E0] |=> flag_reg[E0]) else $error("ext0 flag not set");
  a_accept_gate: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    start && !I_SPECIAL_REQ && !I_SOFT_REQ |-> flg_reg[FLG_IEN_POS]) else $error("accept w/o I");
  a_mask_block: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mask_reg == LVL_MAX |-> !best_vld) else $error("mask 7 leaked");
  a_ien_clear: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    start |=> !flg_reg[FLG_IEN_POS]) else $error("enable not cleared");
  a_mask_load: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    start && best_vld && !I_SPECIAL_REQ && !I_SOFT_REQ |-> ##8 mask_reg == $past(best_lvl, 8))
    else $error("mask not loaded");
  a_port_raw: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    1'b1 |=> port_reg == $past(I_EXT3_INPUT)) else $error("port not raw");
endmodule : mipc_ctrl

// ### mipc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mipc_ctrl_tb;
  import mipc_pkg::*;
  logic                I_CLK = 1'b0;
  logic                I_SYS_RST = 1'b1;
  logic [7:0]          src_req = 8'h00;
  logic [23:0]         src_lvl = 24'h000000;
  logic [7:0]          flag_clr = 8'h00;
  logic                instr_end = 1'b0;
  logic                string_op = 1'b0;
  logic                special_req = 1'b0;
  logic                soft_req = 1'b0;
  logic [5:0]          soft_num = 6'h00;
  logic                return_instr = 1'b0;
  logic [7:0]          pop_data;
  logic [7:0]          flag_in = 8'hC4;
  logic [2:0]          mask_in = 3'h2;
  logic                mask_wr = 1'b0;
  logic [19:0]         pc = 20'hA5C3D;
  logic [19:0]         vector = 20'h01234;
  mipc_ext_cfg_s       cfg = '0;
  logic                ext0 = 1'b1;
  logic                ext3 = 1'b1;
  logic [2:0]          tick = 3'h0;
  logic [7:0]          req_flag;
  logic [2:0]          mask;
  logic [7:0]          flags;
  logic [19:0]         pc_out;
  logic                pc_load;
  mipc_bus_s           bus;
  logic                busy;
  logic                suspend;
  logic [7:0]          info;
  logic                port3;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;
  // clock at 40 MHz
  initial begin
    forever #12.5 I_CLK = ~I_CLK;
  end
  mipc_ctrl u_mipc_ctrl (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_SRC_REQ(src_req), .I_SRC_LVL(src_lvl),
    .I_FLAG_CLR(flag_clr), .I_INSTR_END(instr_end), .I_STRING_OP(string_op),
    .I_SPECIAL_REQ(special_req), .I_SOFT_REQ(soft_req), .I_SOFT_NUM(soft_num),
    .I_RETURN_INSTR(return_instr), .I_POP_DATA(pop_data), .I_FLAG_IN(flag_in),
    .I_MASK_IN(mask_in), .I_MASK_WR(mask_wr), .I_PC(pc), .I_VECTOR(vector),
    .I_EXT_CFG(cfg), .I_EXT0_INPUT(ext0), .I_EXT1_FIRST_PIN(1'b1),
    .I_EXT1_SECOND_PIN(1'b1), .I_EXT3_INPUT(ext3), .I_SAMPLE_TICK(tick),
    .I_CAPTURE_TICK(1'b0), .I_RING_CLK(1'b0), .I_RING_HALF(1'b0),
    .O_REQ_FLAG(req_flag), .O_MASK(mask), .O_FLAGS(flags), .O_PC(pc_out),
    .O_PC_LOAD(pc_load), .O_BUS(bus), .O_ENTRY_BUSY(busy), .O_SUSPEND(suspend),
    .O_INFO(info), .O_PORT3_LINE3(port3)
  );
  mipc_stack_model u_mipc_stack_model (.I_CLK(I_CLK), .i_bus(bus), .o_pop_data(pop_data));
  // n edges, then let their updates settle before looking
  task automatic step(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask : step
  task automatic conclude;
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // walk one entry: trigger held one edge, then check each cycle of the sequence
  task automatic entry(input logic use_str, input logic [7:0] exp_info,
                       input logic [2:0] exp_mask, input logic [7:0] exp_b0,
                       input logic chk_flags);
    logic [7:0] exp_bytes [4];
    exp_bytes = '{exp_b0, flag_in, pc[15:8], pc[7:0]};
    @(posedge I_CLK);
    if (use_str) string_op <= 1'b1;
    else instr_end <= 1'b1;
    @(posedge I_CLK);
    instr_end <= 1'b0;
    string_op <= 1'b0;
    #1;
    `CHK(bus.rd, 1'b1)
    `CHK(bus.addr, INFO_ADDR)
    `CHK(suspend, use_str)
    for (int k = 1; k <= 20; k++) begin
      step(1);
      if (k == 1) `CHK(info, exp_info)
      if (k >= 3 && k <= 6) begin
        `CHK(bus.wr, 1'b1)
        if (k == 3 || chk_flags) `CHK(bus.wdata, exp_bytes[k-3])
      end
      if (k == 8) `CHK(mask, exp_mask)
      if (k < 20) `CHK(pc_load, 1'b0)
    end
    `CHK(pc_load, 1'b1)
    `CHK(pc_out, vector)
    `CHK(flags[FLG_IEN_POS], 1'b0)
    `CHK(flags[FLG_DSTEP_POS], 1'b0)
  endtask : entry
  initial begin
    step(5);
    I_SYS_RST <= 1'b0;
    step(1);
    `CHK(req_flag, 8'h00)
    `CHK(port3, 1'b1)
    // sources 4 and 5 tie at level 5, source 6 at level 3, mask 2
    src_lvl <= {3'h0, 3'h3, 3'h5, 3'h5, 12'h000};
    mask_wr <= 1'b1;
    src_req <= 8'h70;
    step(1);
    mask_wr <= 1'b0;
    src_req <= 8'h00;
    step(2);
    `CHK(req_flag, 8'h70)
    entry(1'b0, {2'b00, 3'h4, 3'h5}, 3'h5, {pc[19:16], 1'b0, 3'h2}, 1'b1);
    `CHK(req_flag, 8'h60)
    // mask 5 now blocks levels 5 and 3
    @(posedge I_CLK);
    instr_end <= 1'b1;
    step(1);
    instr_end <= 1'b0;
    step(3);
    `CHK(busy, 1'b0)
    `CHK(bus.rd, 1'b0)
    // software clear writes zero only
    flag_clr <= 8'h20;
    step(1);
    flag_clr <= 8'h00;
    step(2);
    `CHK(req_flag, 8'h40)
    // special source during a string instruction loads level 7
    special_req <= 1'b1;
    entry(1'b1, 8'h00, 3'h7, {pc[19:16], 1'b0, 3'h5}, 1'b0);
    special_req <= 1'b0;
    // software number above 31 leaves the mask as is
    soft_num <= 6'h28;
    soft_req <= 1'b1;
    entry(1'b0, 8'h00, 3'h7, {pc[19:16], 1'b0, 3'h7}, 1'b1);
    soft_req <= 1'b0;
    // return pops flags and pc pushed by the last entry
    @(posedge I_CLK);
    return_instr <= 1'b1;
    @(posedge I_CLK);
    return_instr <= 1'b0;
    step(5);
    `CHK(pc_load, 1'b1)
    `CHK(pc_out, pc)
    `CHK(flags, flag_in)
    `CHK(mask, 3'h7)
    step(4);
    // ext0 both edges, falling polarity kept at zero, sampled every cycle
    cfg.e0_both <= 1'b1;
    step(4);
    ext0 <= 1'b0;
    step(8);
    `CHK(req_flag[0], 1'b0)
    cfg.e0_en <= 1'b1;
    step(2);
    ext0 <= 1'b1;
    step(1);
    `CHK(req_flag[0], 1'b0)
    for (int w = 0; w <= 10 && req_flag[0] !== 1'b1; w++) step(1);
    `CHK(req_flag[0], 1'b1)
    // raw pin level shown on the port bit, filter or not
    cfg.e3_clk_sel <= 2'h3;
    ext3 <= 1'b0;
    step(3);
    `CHK(port3, 1'b0)
    conclude();
  end
  // hang guard
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule : mipc_ctrl_tb

// ### mipc_pkg.sv
package mipc_pkg;
  // source count and field widths
  localparam int NUM_SRC       = 8;
  localparam int LVL_W         = 3;
  localparam int IDX_W         = 3;
  localparam int FLG_W         = 8;
  localparam int PC_W          = 20;
  // flag register bit positions
  localparam int FLG_USTACK_POS = 7;
  localparam int FLG_IEN_POS    = 6;
  localparam int FLG_DSTEP_POS  = 2;
  // level codes
  localparam logic [2:0] LVL_OFF   = 3'h0;
  localparam logic [2:0] LVL_MAX   = 3'h7;
  // entry sequence length and first read address
  localparam int ENTRY_CYCLES  = 20;
  localparam logic [19:0] INFO_ADDR = 20'h00000;
  // filter agreement count
  localparam int FILT_MATCH    = 3;
  // accepted source class codes: maskable, special, soft
  localparam logic [1:0] CLS_MASKABLE = 2'h0;
  localparam logic [1:0] CLS_SPECIAL  = 2'h1;
  localparam logic [1:0] CLS_SOFT     = 2'h2;

  typedef enum logic [2:0] {
    MIPC_IDLE  = 3'b000,
    MIPC_INFO  = 3'b001,
    MIPC_PUSH  = 3'b011,
    MIPC_LOAD  = 3'b010,
    MIPC_RET   = 3'b110
  } mipc_state_e;

  // bus cycle driven by the core sequencer
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } mipc_bus_s;

  // ext pin configuration
  typedef struct packed {
    logic       e0_en;
    logic       e0_both;
    logic       e0_pol;
    logic [1:0] e0_clk_sel;
    logic       e1_edge;
    logic       e1_pin_sel;
    logic       e3_src_sel;
    logic       e3_sync_sel;
    logic [1:0] e3_clk_sel;
  } mipc_ext_cfg_s;
endpackage : mipc_pkg

// ### mipc_stack_model.sv
`timescale 1ns/1ps
// stack memory beside the core: keeps pushed bytes, answers pops
module mipc_stack_model (
  input  wire logic                I_CLK,
  input  wire mipc_pkg::mipc_bus_s i_bus,
  output logic [7:0]               o_pop_data
);
  import mipc_pkg::*;
  logic [7:0] mem_reg [0:31];
  // byte-wide store, one per write strobe
  always_ff @(posedge I_CLK) begin
    if (i_bus.wr) begin
      mem_reg[i_bus.addr[4:0]] <= i_bus.wdata;
    end
  end
  // pop data follows the read address; unwritten places read as x on purpose
  assign o_pop_data = mem_reg[i_bus.addr[4:0]];
endmodule : mipc_stack_model
